// File: common/tmc_regs.svh
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// Register byte addresses on the APB window
`define TMC_OFS_CONTROL      8'h00
`define TMC_OFS_COUNT_LOW    8'h04
`define TMC_OFS_COUNT_HIGH   8'h08
`define TMC_OFS_FLAGS        8'h0c
`define TMC_OFS_ENABLES      8'h10

// timer_control fields
`define TMC_CTRL_WIDE_BIT    7
`define TMC_CTRL_PRE_HI      5
`define TMC_CTRL_PRE_LO      4
`define TMC_CTRL_OSC_BIT     3
`define TMC_CTRL_BYPASS_BIT  2
`define TMC_CTRL_SRC_BIT     1
`define TMC_CTRL_RUN_BIT     0
`define TMC_CTRL_WMASK       8'hbf
`define TMC_CTRL_RESET       8'h00

// peripheral_flags_one / peripheral_enables_one fields
`define TMC_FLAG_OVF_BIT     0
`define TMC_FLAGS_RESET      8'h00
`define TMC_ENABLES_RESET    8'h00

// Count range and compare mode that asks for the special event trigger
`define TMC_COUNT_RESET      16'h0000
`define TMC_COUNT_MAX        16'hffff
`define TMC_CMP_SPECIAL      4'hb

// Instruction clock is the core clock divided by four
`define TMC_INSTR_DIV        4

`endif

// File: common/tmc_pkg.sv
package tmc_pkg;

  // Effective count path after the source and bypass bits are resolved
  typedef enum logic [1:0] {
    SRC_INTERNAL,
    SRC_EXT_SYNC,
    SRC_EXT_ASYNC
  } tmc_src_t;

endpackage

// File: rtl/tmc_prescaler.sv
module tmc_prescaler (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       clear,
  input  wire logic       tickIn,
  input  wire logic [1:0] divSel,
  output logic            tickOut
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [2:0] mask;

  // 00 -> 1:1, 01 -> 1:2, 10 -> 1:4, 11 -> 1:8
  assign mask    = 3'((4'h1 << divSel) - 4'h1);
  assign tickOut = tickIn && !clear && ((cnt_q & mask) == mask);
  assign cnt_d   = clear ? 3'h0 : (tickIn ? cnt_q + 3'h1 : cnt_q);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= 3'h0;
    else
      cnt_q <= cnt_d;
  end

endmodule // tmc_prescaler

// File: rtl/tmc_edge_detect.sv
module tmc_edge_detect (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic pinIn,
  input  wire logic bypassSync,
  output logic      risePulse
);

  logic syncA_q;
  logic syncB_q;
  logic syncPrev_q;
  logic rawPrev_q;
  logic syncRise;
  logic rawRise;

  assign syncRise  = syncB_q && !syncPrev_q;
  // Bypass path trusts the pin as already clean; two cycles less latency
  assign rawRise   = pinIn && !rawPrev_q;
  assign risePulse = bypassSync ? rawRise : syncRise;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA_q    <= 1'b0;
      syncB_q    <= 1'b0;
      syncPrev_q <= 1'b0;
      rawPrev_q  <= 1'b0;
    end
    else
    begin
      syncA_q    <= pinIn;
      syncB_q    <= syncA_q;
      syncPrev_q <= syncB_q;
      rawPrev_q  <= pinIn;
    end
  end

endmodule // tmc_edge_detect

// File: rtl/tmc_timer.sv
// Design decisions made here: the placing of the registers and register access over APB.
`include "tmc_regs.svh"

// Function
// - Control bit 7 selects buffered 16-bit access or two independent byte accesses.
// - Prescale field bits 5-4 divides the count clock by 1, 2, 4 or 8.
// - Control bit 3 enables the low-power oscillator; clear shuts it off.
// - External source: bit 2 clear synchronizes, set bypasses; ignored for internal.
// - Bit 1 picks external pin rising edges or the quarter-rate internal clock.
// - Control bit 0 runs the counter; clear stops incrementing.
// - Count wraps from FFFF to 0000 and each wrap latches the overflow flag.
// - Interrupt request only while the overflow flag and its enable are set.
// - Compare mode 1011 trigger zeroes the count and, with the converter enabled, starts a conversion.
// - The trigger reset never sets the overflow flag.
// - Trigger reset works for internal or synchronized counting only.
// - A software count write beats a coincident trigger reset.
// - Buffered mode: low byte read snapshots high byte; high reads return snapshot.
// - Buffered mode: high writes fill buffer; low write moves it into the count.
// - Low byte writes clear the prescaler; high byte writes do not.
module tmc_timer #(
  parameter int CountWidth = 16
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        externalCountClockPin,
  input  wire logic [3:0]  compareModeSel,
  input  wire logic        specialEventTrigger,
  input  wire logic        adcEnabled,
  output logic             overflowIrq,
  output logic             adcStartPulse,
  output logic             lowPowerOscEnable
);

  // Register state
  logic [7:0]            control_q;
  logic [7:0]            control_d;
  logic [CountWidth-1:0] count_q;
  logic [CountWidth-1:0] count_d;
  logic [7:0]            highBuf_q;
  logic [7:0]            highBuf_d;
  logic                  ovfFlag_q;
  logic                  ovfFlag_d;
  logic                  ovfEnable_q;
  logic                  ovfEnable_d;
  logic [31:0]           prdata_q;
  logic [31:0]           prdata_d;
  logic                  adcStart_q;
  logic                  adcStart_d;

  // Instruction clock divider
  logic [1:0]            instrDiv_q;
  logic [1:0]            instrDiv_d;
  logic                  instrTick;

  // Control fields
  logic                  wideAccessMode;
  logic [1:0]            inputPrescaleSel;
  logic                  lowPowerOscEn;
  logic                  syncBypass;
  logic                  countSourceSel;
  logic                  countRun;

  assign wideAccessMode   = control_q[`TMC_CTRL_WIDE_BIT];
  assign inputPrescaleSel = control_q[`TMC_CTRL_PRE_HI:`TMC_CTRL_PRE_LO];
  assign lowPowerOscEn    = control_q[`TMC_CTRL_OSC_BIT];
  assign syncBypass       = control_q[`TMC_CTRL_BYPASS_BIT];
  assign countSourceSel   = control_q[`TMC_CTRL_SRC_BIT];
  assign countRun         = control_q[`TMC_CTRL_RUN_BIT];

  // APB decode
  logic                  setupPhase;
  logic                  accessPhase;
  logic                  wrAccess;
  logic                  rdSetup;
  logic                  hitControl;
  logic                  hitLow;
  logic                  hitHigh;
  logic                  hitFlags;
  logic                  hitEnables;
  logic                  mapped;
  logic                  wrControl;
  logic                  wrLow;
  logic                  wrHigh;
  logic                  wrFlags;
  logic                  wrEnables;
  logic                  rdLowSetup;

  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign wrAccess    = accessPhase && pwrite;
  assign rdSetup     = setupPhase && !pwrite;

  assign hitControl  = paddr == `TMC_OFS_CONTROL;
  assign hitLow      = paddr == `TMC_OFS_COUNT_LOW;
  assign hitHigh     = paddr == `TMC_OFS_COUNT_HIGH;
  assign hitFlags    = paddr == `TMC_OFS_FLAGS;
  assign hitEnables  = paddr == `TMC_OFS_ENABLES;
  assign mapped      = hitControl || hitLow || hitHigh || hitFlags || hitEnables;

  assign wrControl   = wrAccess && hitControl;
  assign wrLow       = wrAccess && hitLow;
  assign wrHigh      = wrAccess && hitHigh;
  assign wrFlags     = wrAccess && hitFlags;
  assign wrEnables   = wrAccess && hitEnables;
  assign rdLowSetup  = rdSetup && hitLow;

  // Zero wait states; unmapped addresses answer with an error
  assign pready      = 1'b1;
  assign pslverr     = accessPhase && !mapped;
  assign prdata      = prdata_q;

  // Count source resolution
  tmc_pkg::tmc_src_t     srcMode;
  logic                  extRise;
  logic                  srcTick;
  logic                  preTick;
  logic                  countTick;

  assign srcMode = !countSourceSel ? tmc_pkg::SRC_INTERNAL :
                   (syncBypass ? tmc_pkg::SRC_EXT_ASYNC : tmc_pkg::SRC_EXT_SYNC);

  tmc_edge_detect u_edge (
    .clk        (clk),
    .arst_n     (arst_n),
    .pinIn      (externalCountClockPin),
    .bypassSync (srcMode == tmc_pkg::SRC_EXT_ASYNC),
    .risePulse  (extRise)
  );

  // Core clock stands for the oscillator, so the instruction rate is a quarter of it
  assign instrDiv_d = 2'(instrDiv_q + 2'h1);
  assign instrTick  = instrDiv_q == 2'(`TMC_INSTR_DIV - 1);

  assign srcTick = (srcMode == tmc_pkg::SRC_INTERNAL) ? instrTick : extRise;

  tmc_prescaler u_pre (
    .clk     (clk),
    .arst_n  (arst_n),
    .clear   (wrLow),
    .tickIn  (srcTick && countRun),
    .divSel  (inputPrescaleSel),
    .tickOut (preTick)
  );

  // Stopped counter receives no ticks and so keeps its value
  assign countTick = preTick && countRun;

  // Special event trigger
  logic                  cmpSpecial;
  logic                  trigReset;
  logic                  countWrite;
  logic                  wrap;

  assign cmpSpecial = specialEventTrigger && (compareModeSel == `TMC_CMP_SPECIAL);
  // Trigger is not honoured on the unsynchronized path, where it cannot be made reliable
  assign trigReset  = cmpSpecial && (srcMode != tmc_pkg::SRC_EXT_ASYNC);
  assign countWrite = wrLow || (wrHigh && !wideAccessMode);
  assign wrap       = countTick && !countWrite && !trigReset
                      && (count_q == `TMC_COUNT_MAX);

  // Next count: software write first, then trigger reset, then increment
  always_comb
  begin
    count_d = count_q;
    if (wrLow && wideAccessMode)
      count_d = {highBuf_q, pwdata[7:0]};
    else if (wrLow)
      count_d = {count_q[15:8], pwdata[7:0]};
    else if (wrHigh && !wideAccessMode)
      count_d = {pwdata[7:0], count_q[7:0]};
    else if (trigReset)
      count_d = `TMC_COUNT_RESET;
    else if (countTick)
      count_d = CountWidth'(count_q + 16'h0001);
  end

  // Holding buffer for coherent 16-bit access
  always_comb
  begin
    highBuf_d = highBuf_q;
    if (wrHigh && wideAccessMode)
      highBuf_d = pwdata[7:0];
    else if (rdLowSetup && wideAccessMode)
      highBuf_d = count_q[15:8];
  end

  // Control register; bit 6 is unimplemented and stays zero
  assign control_d = wrControl ? (pwdata[7:0] & `TMC_CTRL_WMASK) : control_q;

  // Overflow flag: a wrap in the same cycle as a software clear keeps the flag set
  always_comb
  begin
    ovfFlag_d = ovfFlag_q;
    if (wrFlags)
      ovfFlag_d = pwdata[`TMC_FLAG_OVF_BIT];
    if (wrap)
      ovfFlag_d = 1'b1;
  end

  assign ovfEnable_d = wrEnables ? pwdata[`TMC_FLAG_OVF_BIT] : ovfEnable_q;
  assign overflowIrq = ovfFlag_q && ovfEnable_q;

  // Conversion start follows any mode 1011 trigger while the converter is enabled, honoured or not; a write that wins still starts it
  assign adcStart_d    = cmpSpecial && adcEnabled;
  assign adcStartPulse = adcStart_q;

  assign lowPowerOscEnable = lowPowerOscEn;

  // Read data is captured in the setup phase, so the access phase returns it at once
  always_comb
  begin
    prdata_d = prdata_q;
    if (rdSetup)
    begin
      prdata_d = 32'h0000_0000;
      if (hitControl)
        prdata_d[7:0] = control_q;
      else if (hitLow)
        prdata_d[7:0] = count_q[7:0];
      else if (hitHigh)
        prdata_d[7:0] = wideAccessMode ? highBuf_q : count_q[15:8];
      else if (hitFlags)
        prdata_d[`TMC_FLAG_OVF_BIT] = ovfFlag_q;
      else if (hitEnables)
        prdata_d[`TMC_FLAG_OVF_BIT] = ovfEnable_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      control_q   <= `TMC_CTRL_RESET;
      count_q     <= `TMC_COUNT_RESET;
      highBuf_q   <= 8'h00;
      ovfFlag_q   <= 1'b0;
      ovfEnable_q <= 1'b0;
      prdata_q    <= 32'h0000_0000;
      adcStart_q  <= 1'b0;
      instrDiv_q  <= 2'h0;
    end
    else
    begin
      control_q   <= control_d;
      count_q     <= count_d;
      highBuf_q   <= highBuf_d;
      ovfFlag_q   <= ovfFlag_d;
      ovfEnable_q <= ovfEnable_d;
      prdata_q    <= prdata_d;
      adcStart_q  <= adcStart_d;
      instrDiv_q  <= instrDiv_d;
    end
  end

endmodule // tmc_timer

// File: test/tmc_timer_monitor.sv
module tmc_timer_monitor (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        externalCountClockPin,
  input wire logic [3:0]  compareModeSel,
  input wire logic        specialEventTrigger,
  input wire logic        adcEnabled,
  input wire logic        overflowIrq,
  input wire logic        adcStartPulse,
  input wire logic        lowPowerOscEnable
);
  timeunit 1ns;
  timeprecision 1ns;
  wire acc = psel && penable;
  wire wrCtl = acc && pwrite && paddr == 8'h00;
  wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  wire fire = specialEventTrigger && compareModeSel == 4'hb && adcEnabled;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_ready_high: assert property (pready) else $error("pready low");
  a_slverr_set: assert property (acc && !mapped |-> pslverr) else $error("no slverr");
  a_slverr_clr: assert property (!(acc && !mapped) |-> !pslverr) else $error("stray slverr");
  a_rd_unmapped: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_rd_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_osc_follow: assert property (wrCtl |=> lowPowerOscEnable == $past(pwdata[3]))
    else $error("oscillator enable wrong");
  a_osc_hold: assert property (!wrCtl |=> $stable(lowPowerOscEnable))
    else $error("oscillator enable moved");
  a_adc_start: assert property (fire |=> adcStartPulse)
    else $error("no conversion start");
  a_adc_cause: assert property (adcStartPulse |-> $past(fire))
    else $error("spurious conversion start");
  a_irq_mask: assert property (acc && pwrite && paddr == 8'h10 && !pwdata[0] |=> !overflowIrq)
    else $error("irq while disabled");
  c_fire: cover property (fire);
  c_irq: cover property (overflowIrq);
  c_unmapped: cover property (acc && !mapped);
endmodule // tmc_timer_monitor

bind tmc_timer tmc_timer_monitor mon_u (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .externalCountClockPin(externalCountClockPin), .compareModeSel(compareModeSel),
  .specialEventTrigger(specialEventTrigger), .adcEnabled(adcEnabled),
  .overflowIrq(overflowIrq), .adcStartPulse(adcStartPulse),
  .lowPowerOscEnable(lowPowerOscEnable)
);

// File: test/tmc_cmp_model.sv
module tmc_cmp_model (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic fire,
  input  wire logic extRun,
  output logic      specialEventTrigger,
  output logic      externalCountClockPin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      specialEventTrigger <= 1'b0;
      phase_q             <= 2'h0;
    end
    else
    begin
      specialEventTrigger <= fire;
      if (extRun)
        phase_q <= phase_q + 2'h1;
    end
  end
  // Clock rests low between bursts, so no stray edge reaches the counter
  assign externalCountClockPin = phase_q[1];
endmodule // tmc_cmp_model

// File: test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} tmc_row_t;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v;
  logic        pin, trig, adcEn, irq, adcGo, osc, fire, extRun;
  logic [3:0]  mode;
  int          fails, n_tests;
  // Bit 6 is unimplemented, so a write of all ones reads back with it clear
  tmc_row_t rows[5] = '{'{8'h00, 32'hff, 32'hbf}, '{8'h00, 32'h08, 32'h08},
    '{8'h10, 32'h01, 32'h01}, '{8'h10, 32'h00, 32'h00}, '{8'h14, 32'hff, 32'h00}};

  tmc_timer dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .externalCountClockPin(pin), .compareModeSel(mode),
    .specialEventTrigger(trig), .adcEnabled(adcEn), .overflowIrq(irq),
    .adcStartPulse(adcGo), .lowPowerOscEnable(osc));
  tmc_cmp_model cmp_u (.clk(clk), .arst_n(arst_n), .fire(fire), .extRun(extRun),
    .specialEventTrigger(trig), .externalCountClockPin(pin));

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    fire    <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (k >= 50)
    begin
      fails++;
      print_verdict();
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      fails++;
      $display("MISMATCH %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, lo, hi);
  endtask

  task automatic pulse;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, fire, extRun} = '0;
    mode = 4'hb;
    adcEn = 1'b1;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
      rdc(8'(4 * i), 32'h0, 32'h0);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e, rows[i].e);
    end
    // Start and stop edges are both APB writes, so the window is fixed
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h00, 32'(p << 4));
      wr(8'h08, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'((p << 4) | 1));
      repeat ((32 << p) - 2) @(posedge clk);
      wr(8'h00, 32'(p << 4));
      rdc(8'h04, 32'h7, 32'h9);
    end
    apb(1'b0, 8'h04, 32'h0, v);
    repeat (40) @(posedge clk);
    rdc(8'h04, v, v);
    wr(8'h08, 32'hff);
    wr(8'h04, 32'hfe);
    wr(8'h00, 32'h01);
    repeat (20) @(posedge clk);
    chk({31'h0, irq}, 32'h0, 32'h0);
    rdc(8'h0c, 32'h1, 32'h1);
    rdc(8'h08, 32'h0, 32'h0);
    wr(8'h10, 32'h1);
    chk({31'h0, irq}, 32'h1, 32'h1);
    wr(8'h0c, 32'h0);
    chk({31'h0, irq}, 32'h0, 32'h0);
    wr(8'h00, 32'h31);
    for (int m = 0; m < 2; m++)
    begin
      mode <= m ? 4'ha : 4'hb;
      wr(8'h08, 32'h50);
      wr(8'h04, 32'h77);
      pulse();
      rdc(8'h08, m ? 32'h50 : 32'h0, m ? 32'h50 : 32'h0);
      rdc(8'h0c, 32'h0, 32'h0);
    end
    mode <= 4'hb;
    fire <= 1'b1;
    wr(8'h04, 32'h66);
    rdc(8'h04, 32'h66, 32'h67);
    rdc(8'h08, 32'h50, 32'h50);
    // Converter off here, so the checker sees a trigger that must not start it
    adcEn <= 1'b0;
    wr(8'h00, 32'h07);
    pulse();
    adcEn <= 1'b1;
    rdc(8'h08, 32'h50, 32'h50);
    for (int b = 0; b < 2; b++)
    begin
      wr(8'h00, 32'(3 | (b << 2)));
      wr(8'h08, 32'h0);
      wr(8'h04, 32'h0);
      extRun <= 1'b1;
      repeat (20) @(posedge clk);
      extRun <= 1'b0;
      repeat (6) @(posedge clk);
      rdc(8'h04, 32'h5, 32'h5);
    end
    wr(8'h00, 32'h80);
    wr(8'h08, 32'hab);
    wr(8'h04, 32'hcd);
    wr(8'h00, 32'h0);
    rdc(8'h08, 32'hab, 32'hab);
    wr(8'h00, 32'h80);
    wr(8'h08, 32'h11);
    rdc(8'h04, 32'hcd, 32'hcd);
    wr(8'h00, 32'h0);
    rdc(8'h08, 32'hab, 32'hab);
    wr(8'h08, 32'h22);
    wr(8'h00, 32'h80);
    rdc(8'h08, 32'hab, 32'hab);
    // Timekeeping use: unsynchronized count, irq enabled, oscillator on
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h0e);
    wr(8'h08, 32'hff);
    wr(8'h04, 32'hfd);
    wr(8'h00, 32'h0f);
    chk({31'h0, osc}, 32'h1, 32'h1);
    extRun <= 1'b1;
    repeat (20) @(posedge clk);
    extRun <= 1'b0;
    repeat (6) @(posedge clk);
    chk({31'h0, irq}, 32'h1, 32'h1);
    // Preload only the high byte MSB; the low byte keeps its value of 2 untouched
    wr(8'h08, 32'h80);
    rdc(8'h04, 32'h2, 32'h2);
    rdc(8'h08, 32'h80, 32'h80);
    wr(8'h0c, 32'h0);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdc(8'h00, 32'h0, 32'h0);
    rdc(8'h08, 32'h0, 32'h0);
    print_verdict();
  end
endmodule // tb_top
